// ### design/ssw_bank.sv
// Special status word bank with APB register access
// Behaviour
// - Words 236 to 255 hold the area
// - Flags and controls zero until set; word 253 bit 15 starts at one
// - Restart bit on then off restarts unit
// - Remote error sets word 253 bit 12
// - Word 251 shows first error, queues up to seven more
// - Bit 03 marks any remote error
// - Binary bits 04-06, hex bits 08-15
// - Master failure: B, master, rack
// - Optical failure: unit 0-31 upper field
// - Bit 04 tells upper or lower byte
// - Host link error and restart bits
// - Rack restarts ignored for multilevel units
// - Network transfer error flags per level
// - Network instructions need enable bit
// - Data link active flags per level
// - Word 236 loop status per level
// - Word 237 completion codes per level
// - Link status words; word 246 unused
// - Five free-running pulse bits
// - Word 253 fault code and fixed bits
// - Word 254 step and unit errors
// - Word 255 instruction result flags
//
// Design decision made here: the APB slave port.
`timescale 1ns/1ps
module ssw_bank
   import ssw_pkg::*;
#(
   parameter int unsigned HALF_1MIN  = PER_1MIN_MS * CYC_PER_MS / 2,
   parameter int unsigned HALF_20MS  = PER_20MS_MS * CYC_PER_MS / 2,
   parameter int unsigned HALF_100MS = PER_100MS_MS * CYC_PER_MS / 2,
   parameter int unsigned HALF_200MS = PER_200MS_MS * CYC_PER_MS / 2,
   parameter int unsigned HALF_1S    = PER_1S_MS * CYC_PER_MS / 2
)(
   input  wire logic             sys_clk,
   input  wire logic             rst_b,
   input  wire logic             psel,
   input  wire logic             penable,
   input  wire logic             pwrite,
   input  wire logic [31:0]      paddr,
   input  wire logic [31:0]      pwdata,
   output logic [31:0]           prdata,
   output logic                  pready,
   output logic                  pslverr,
   input  wire ssw_unit_in_type  unitIn,
   output ssw_ctrl_out_type      ctrlOut
);

   typedef struct packed {
      logic [15:0]       ctl;
      logic [7:0]        falCode;
      logic              hostErr0;
      logic              rioErr;
      logic              first;
      logic [15:0]       cmpl;
      logic [4:0]        res;
      logic              chk;
      logic [7:0][15:0]  queue;
      logic [2:0]        head;
      logic [2:0]        tail;
      logic [3:0]        count;
      logic [4:0][31:0]  pcnt;
      logic [4:0]        pulse;
      logic [2:0]        restart;
      logic [31:0]       rdata;
      logic              slverr;
   } ssw_state_type;

   ssw_state_type st_ff;
   ssw_state_type nxt_st;

   localparam int unsigned HALF [5] = '{HALF_1S, HALF_200MS, HALF_100MS,
                                        HALF_20MS, HALF_1MIN};

   logic        setup;
   logic        wrAcc;
   logic [7:0]  widx;
   logic        mapped;
   logic [15:0] wRio;
   logic [15:0] wCtl;
   logic [15:0] wSys;
   logic [15:0] wUnit;
   logic [15:0] wRes;
   logic [15:0] wRd;
   logic [15:0] rioEnc;
   logic        pop;
   logic        push;
   logic [15:0] wd;

   assign pready = 1'b1;
   assign prdata = st_ff.rdata;
   assign pslverr = st_ff.slverr;

   always_comb begin
      setup = psel & ~penable;
      wrAcc = psel & penable & pwrite;
      widx = paddr[9:2];
      wd = pwdata[15:0];
      // Upper address bits must be clear for a hit
      mapped = (paddr[31:10] == 22'h000000) && (paddr[1:0] == 2'h0)
               && (widx >= IDX_LOOP);

      // Encoding of one remote unit report
      rioEnc = WORD_RST;
      rioEnc[RIO_FLAG] = 1'b1;
      if (unitIn.rioIsMaster) begin
         rioEnc[15:12] = RIO_MASTER_TAG;
         rioEnc[11:8] = {3'h0, unitIn.rioMasterNo};
         rioEnc[6:4] = unitIn.rioRack;
      end else begin
         rioEnc[15:8] = {3'h0, unitIn.rioOptUnit};
         rioEnc[4] = unitIn.rioUpper;
      end

      wRio = (st_ff.count != 4'h0) ? st_ff.queue[st_ff.head] : WORD_RST;
      wRio[RIO_CHECK] = st_ff.chk;

      wCtl = st_ff.ctl;
      wCtl[CTL_LINK0] = unitIn.linkAct0;
      wCtl[CTL_LINK1] = unitIn.linkAct1;

      wSys = {st_ff.first, 1'b0, 1'b1, st_ff.rioErr, st_ff.hostErr0,
              unitIn.ioVerErr, unitIn.cycTimeErr, unitIn.lowBatt,
              st_ff.falCode};

      wUnit = WORD_RST;
      wUnit[0] = st_ff.pulse[4];
      wUnit[1] = st_ff.pulse[3];
      wUnit[7] = unitIn.stepFlag;
      wUnit[14] = unitIn.hdioErr;
      wUnit[15] = unitIn.specUnitErr;

      // Word 255 holds 0.1 s at bit 00 and 1.0 s at bit 02
      wRes = {8'h00, st_ff.res, st_ff.pulse[0], st_ff.pulse[1],
              st_ff.pulse[2]};

      unique case (widx)
         IDX_LOOP:   wRd = unitIn.loopStat;
         IDX_CMPL:   wRd = st_ff.cmpl;
         8'hEE:      wRd = unitIn.linkStat0[15:0];
         8'hEF:      wRd = unitIn.linkStat0[31:16];
         8'hF0:      wRd = unitIn.linkStat0[47:32];
         8'hF1:      wRd = unitIn.linkStat0[63:48];
         8'hF2:      wRd = unitIn.linkStat1[15:0];
         8'hF3:      wRd = unitIn.linkStat1[31:16];
         8'hF4:      wRd = unitIn.linkStat1[47:32];
         8'hF5:      wRd = unitIn.linkStat1[63:48];
         8'hF7:      wRd = unitIn.unitRunErr[15:0];
         8'hF8:      wRd = unitIn.unitRunErr[31:16];
         8'hF9:      wRd = unitIn.unitRunErr[47:32];
         8'hFA:      wRd = unitIn.unitRunErr[63:48];
         IDX_RIO:    wRd = wRio;
         IDX_CTRL:   wRd = wCtl;
         IDX_SYS:    wRd = wSys;
         IDX_UNIT:   wRd = wUnit;
         IDX_RESULT: wRd = wRes;
         default:    wRd = WORD_RST;
      endcase
   end

   always_comb begin
      nxt_st = st_ff;
      nxt_st.restart = 3'h0;

      // Read data and error are captured in setup for a zero-wait access
      if (setup) begin
         nxt_st.rdata = mapped ? {16'h0000, wRd} : 32'h00000000;
         nxt_st.slverr = ~mapped;
      end

      // Software writes at the access edge
      if (wrAcc && mapped) begin
         unique case (widx)
            IDX_CTRL: begin
               nxt_st.ctl = (st_ff.ctl & ~CTL_RW_MASK)
                            | (wd & CTL_RW_MASK);
               nxt_st.ctl = nxt_st.ctl & ~(CTL_W0C_MASK & ~wd);
            end
            IDX_SYS: begin
               if (!wd[SYS_HERR_R0])
                  nxt_st.hostErr0 = 1'b0;
               if (!wd[SYS_RIOERR])
                  nxt_st.rioErr = 1'b0;
            end
            IDX_RIO: nxt_st.chk = wd[RIO_CHECK];
            default: nxt_st.chk = st_ff.chk;
         endcase
      end

      // Hardware sets after software clears, so a same-cycle event wins
      if (unitIn.netErr0)
         nxt_st.ctl[CTL_NETERR0] = 1'b1;
      if (unitIn.netErr1)
         nxt_st.ctl[CTL_NETERR1] = 1'b1;
      if (unitIn.hostErr[0])
         nxt_st.ctl[CTL_HERR_R1] = 1'b1;
      if (unitIn.hostErr[1])
         nxt_st.ctl[CTL_HERR_C] = 1'b1;
      if (unitIn.hostErr[2])
         nxt_st.hostErr0 = 1'b1;
      nxt_st.ctl[CTL_LINK0] = 1'b0;
      nxt_st.ctl[CTL_LINK1] = 1'b0;

      // Restart on fall of a bit that was set
      if (st_ff.ctl[CTL_RST_R1] && !nxt_st.ctl[CTL_RST_R1]
          && !unitIn.hostMultilevel)
         nxt_st.restart[0] = 1'b1;
      if (st_ff.ctl[CTL_RST_C] && !nxt_st.ctl[CTL_RST_C])
         nxt_st.restart[1] = 1'b1;
      if (st_ff.ctl[CTL_RST_R0] && !nxt_st.ctl[CTL_RST_R0]
          && !unitIn.hostMultilevel)
         nxt_st.restart[2] = 1'b1;

      // Completion codes
      if (unitIn.cmplVld0)
         nxt_st.cmpl[7:0] = unitIn.cmplCode0;
      if (unitIn.cmplVld1)
         nxt_st.cmpl[15:8] = unitIn.cmplCode1;

      if (unitIn.falVld)
         nxt_st.falCode = unitIn.falCode;
      if (unitIn.resVld)
         nxt_st.res = unitIn.resFlags;
      if (unitIn.scanDone)
         nxt_st.first = 1'b0;

      // Remote error queue; a full queue drops the newest report
      pop = st_ff.chk && !nxt_st.chk && (st_ff.count != 4'h0);
      push = unitIn.rioVld && (st_ff.count != 4'(RIO_DEPTH) || pop);
      if (pop)
         nxt_st.head = st_ff.head + 3'h1;
      if (push) begin
         nxt_st.queue[st_ff.tail] = rioEnc;
         nxt_st.tail = st_ff.tail + 3'h1;
      end
      nxt_st.count = st_ff.count + {3'h0, push} - {3'h0, pop};
      if (unitIn.rioVld)
         nxt_st.rioErr = 1'b1;

      // Free-running pulse dividers
      for (int i = 0; i < 5; i++) begin
         if (st_ff.pcnt[i] >= HALF[i] - 1) begin
            nxt_st.pcnt[i] = 32'h00000000;
            nxt_st.pulse[i] = ~st_ff.pulse[i];
         end else begin
            nxt_st.pcnt[i] = st_ff.pcnt[i] + 32'h00000001;
         end
      end
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         st_ff <= '0;
         st_ff.first <= 1'b1;
      end else begin
         st_ff <= nxt_st;
      end
   end

   always_comb begin
      ctrlOut.netEnable = {st_ff.ctl[CTL_NETEN1],
                           st_ff.ctl[CTL_NETEN0]};
      ctrlOut.hostRestart = st_ff.restart;
      ctrlOut.forceHold = st_ff.ctl[CTL_FHOLD];
      ctrlOut.dataRetain = st_ff.ctl[CTL_RETAIN];
      ctrlOut.outputsOff = st_ff.ctl[CTL_OUTOFF];
      // Alarm only; operation carries on
      ctrlOut.alarmFlash = st_ff.rioErr;
      ctrlOut.pulses = st_ff.pulse;
   end

endmodule

// ### design/ssw_pkg.sv
// Constants and carrier types for the special status word bank
package ssw_pkg;
   // Word indices; byte address is four times the index
   localparam logic [7:0] IDX_LOOP    = 8'hEC;
   localparam logic [7:0] IDX_CMPL    = 8'hED;
   localparam logic [7:0] IDX_LINK0   = 8'hEE;
   localparam logic [7:0] IDX_LINK1   = 8'hF2;
   localparam logic [7:0] IDX_UNUSED  = 8'hF6;
   localparam logic [7:0] IDX_RUNERR  = 8'hF7;
   localparam logic [7:0] IDX_RIO     = 8'hFB;
   localparam logic [7:0] IDX_CTRL    = 8'hFC;
   localparam logic [7:0] IDX_SYS     = 8'hFD;
   localparam logic [7:0] IDX_UNIT    = 8'hFE;
   localparam logic [7:0] IDX_RESULT  = 8'hFF;
   localparam logic [15:0] WORD_RST   = 16'h0000;
   // Bit positions in the link control word
   localparam int CTL_NETERR0 = 0;
   localparam int CTL_NETEN0  = 1;
   localparam int CTL_LINK0   = 2;
   localparam int CTL_NETERR1 = 3;
   localparam int CTL_NETEN1  = 4;
   localparam int CTL_LINK1   = 5;
   localparam int CTL_HERR_R1 = 6;
   localparam int CTL_RST_R1  = 7;
   localparam int CTL_HERR_C  = 8;
   localparam int CTL_RST_C   = 9;
   localparam int CTL_FHOLD   = 11;
   localparam int CTL_RETAIN  = 12;
   localparam int CTL_RST_R0  = 13;
   localparam int CTL_OUTOFF  = 15;
   // Software-writable bits of the link control word
   localparam logic [15:0] CTL_RW_MASK = 16'hBA92;
   // Bits of that word cleared by writing zero
   localparam logic [15:0] CTL_W0C_MASK = 16'h0149;
   // System fault word
   localparam int SYS_HERR_R0 = 11;
   localparam int SYS_RIOERR  = 12;
   // Remote error word
   localparam int  RIO_CHECK  = 0;
   localparam int  RIO_FLAG   = 3;
   localparam logic [3:0] RIO_MASTER_TAG = 4'hB;
   localparam int  RIO_DEPTH  = 8;
   // Pulse periods in milliseconds and clock rate
   localparam int unsigned CLK_HZ      = 20000000;
   localparam int unsigned PER_1MIN_MS = 60000;
   localparam int unsigned PER_20MS_MS = 20;
   localparam int unsigned PER_100MS_MS = 100;
   localparam int unsigned PER_200MS_MS = 200;
   localparam int unsigned PER_1S_MS   = 1000;
   localparam int unsigned CYC_PER_MS  = CLK_HZ / 1000;

   typedef struct packed {
      logic [15:0] loopStat;
      logic        cmplVld0;
      logic [7:0]  cmplCode0;
      logic        cmplVld1;
      logic [7:0]  cmplCode1;
      logic [63:0] linkStat0;
      logic [63:0] linkStat1;
      logic [63:0] unitRunErr;
      logic        netErr0;
      logic        netErr1;
      logic        linkAct0;
      logic        linkAct1;
      logic [2:0]  hostErr;
      logic        hostMultilevel;
      logic        rioVld;
      logic        rioIsMaster;
      logic        rioMasterNo;
      logic [2:0]  rioRack;
      logic [4:0]  rioOptUnit;
      logic        rioUpper;
      logic        falVld;
      logic [7:0]  falCode;
      logic        lowBatt;
      logic        cycTimeErr;
      logic        ioVerErr;
      logic        stepFlag;
      logic        hdioErr;
      logic        specUnitErr;
      logic        resVld;
      logic [4:0]  resFlags;
      logic        scanDone;
   } ssw_unit_in_type;

   typedef struct packed {
      logic [1:0] netEnable;
      logic [2:0] hostRestart;
      logic       forceHold;
      logic       dataRetain;
      logic       outputsOff;
      logic       alarmFlash;
      logic [4:0] pulses;
   } ssw_ctrl_out_type;
endpackage

// ### tb/ssw_bank_asserts.sv
// Concurrent checks on the status word bank ports
`timescale 1ns/1ps
module ssw_bank_asserts
   import ssw_pkg::*;
#(
   parameter int unsigned HALF_20MS = 3
)(
   input wire logic             sys_clk,
   input wire logic             rst_b,
   input wire logic             psel,
   input wire logic             penable,
   input wire logic             pwrite,
   input wire logic [31:0]      paddr,
   input wire logic [31:0]      pwdata,
   input wire logic [31:0]      prdata,
   input wire logic             pready,
   input wire logic             pslverr,
   input wire ssw_unit_in_type  unitIn,
   input wire ssw_ctrl_out_type ctrlOut
);
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rst_b);
   logic        setup;
   logic        bad;
   logic        ctlWr;
   logic [1:0]  enBits;
   logic        prev_ff;
   logic        seen_ff;
   int unsigned run_ff;
   assign setup = psel && !penable;
   assign bad = paddr[31:10] != 22'h0 || paddr[1:0] != 2'h0
                || paddr[9:2] < IDX_LOOP;
   assign ctlWr = psel && penable && pwrite && paddr == 32'h3F0;
   assign enBits = {pwdata[CTL_NETEN1], pwdata[CTL_NETEN0]};
   // First toggle after reset is skipped: its phase is not pinned down
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         prev_ff <= 1'b0;
         seen_ff <= 1'b0;
         run_ff  <= 0;
      end else begin
         prev_ff <= ctrlOut.pulses[3];
         seen_ff <= seen_ff || ctrlOut.pulses[3] != prev_ff;
         run_ff  <= (ctrlOut.pulses[3] != prev_ff) ? 1 : run_ff + 1;
      end
   end
   rdy_high_a: assert property (psel && penable |-> pready)
      else $error("access phase not ready");
   map_err_a: assert property (setup && bad |=> pslverr && !prdata)
      else $error("unmapped access not refused");
   map_ok_a: assert property (setup && !bad |=> !pslverr)
      else $error("mapped access refused");
   fixed_bits_a: assert property (setup && paddr == 32'h3F4 |=>
      prdata[13] && !prdata[14] && prdata[31:16] == 16'h0)
      else $error("fixed bits of system word wrong");
   rio_alarm_a: assert property (unitIn.rioVld |=> ctrlOut.alarmFlash)
      else $error("remote error without alarm");
   net_enable_a: assert property (ctlWr |=>
      ctrlOut.netEnable == $past(enBits))
      else $error("network enable does not follow write");
   cpu_restart_a: assert property ($rose(ctrlOut.hostRestart[1]) |=>
      !ctrlOut.hostRestart[1])
      else $error("restart pulse too long");
   multi_block_a: assert property (unitIn.hostMultilevel &&
      $past(unitIn.hostMultilevel, 2) |->
      !ctrlOut.hostRestart[0] && !ctrlOut.hostRestart[2])
      else $error("rack restart on multilevel unit");
   fast_pulse_a: assert property (seen_ff &&
      ctrlOut.pulses[3] != prev_ff |-> run_ff == HALF_20MS)
      else $error("fast pulse half period wrong");
   unit_pulse_a: assert property (setup && paddr == 32'h3F8 |=>
      prdata[1] == $past(ctrlOut.pulses[3])
      && prdata[0] == $past(ctrlOut.pulses[4]))
      else $error("pulse bits of word 254 misplaced");
   res_pulse_a: assert property (setup && paddr == 32'h3FC |=>
      prdata[2] == $past(ctrlOut.pulses[0])
      && prdata[1] == $past(ctrlOut.pulses[1])
      && prdata[0] == $past(ctrlOut.pulses[2]))
      else $error("pulse bits of word 255 misplaced");
endmodule

bind ssw_bank ssw_bank_asserts #(.HALF_20MS(HALF_20MS)) u_chk (
   .sys_clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata,
   .prdata, .pready, .pslverr, .unitIn, .ctrlOut
);

// ### tb/ssw_bank_tb.sv
// Self-checking bench for the special status word bank
`timescale 1ns/1ps
module ssw_bank_tb
   import ssw_pkg::*;
;
   logic             sys_clk;
   logic             rst_b;
   logic             psel;
   logic             penable;
   logic             pwrite;
   logic [31:0]      paddr;
   logic [31:0]      pwdata;
   logic [31:0]      prdata;
   logic             pready;
   logic             pslverr;
   ssw_unit_in_type  unitIn;
   ssw_ctrl_out_type ctrlOut;
   ssw_unit_in_type  u;
   ssw_unit_in_type  s;
   logic [31:0]      rd;
   logic             err;
   int               failures;
   int               checks;
   int               rstCnt [3];
   ssw_bank #(
      .HALF_1MIN (7),
      .HALF_20MS (3),
      .HALF_100MS(4),
      .HALF_200MS(5),
      .HALF_1S   (6)
   ) uut (
      .sys_clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .unitIn, .ctrlOut
   );
   ssw_unit_model units (.sys_clk, .unitIn);
   initial begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) begin
      for (int i = 0; i < 3; i++) begin
         if (ctrlOut.hostRestart[i] === 1'b1) rstCnt[i]++;
      end
   end
   task automatic chk(input logic [31:0] seen, exp);
      checks++;
      if (seen !== exp) begin
         failures++;
         $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
      end
   endtask
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", checks, failures);
      if (failures == 0 && checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic xfer(input logic w, input logic [31:0] a, d);
      @(posedge sys_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      do @(posedge sys_clk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [31:0] a, d);
      xfer(1'b1, a, d);
   endtask
   task automatic rdchk(input logic [31:0] a, x, input logic e = 1'b0,
                        input logic [31:0] m = 32'hFFFF_FFFF);
      xfer(1'b0, a, 32'h0);
      chk(rd & m, x);
      chk({31'h0, err}, {31'h0, e});
   endtask
   task automatic send();
      units.apply(u, s);
      s = '0;
   endtask
   task automatic pop();
      wr(32'h3EC, 32'h1);
      wr(32'h3EC, 32'h0);
   endtask
   task automatic t_reset();
      rdchk(32'h3F0, 32'h0);
      rdchk(32'h3F4, 32'hA000);
      chk({24'h0, ctrlOut.hostRestart, ctrlOut.netEnable,
           ctrlOut.forceHold, ctrlOut.dataRetain, ctrlOut.outputsOff},
          32'h0);
      s.scanDone = 1'b1;
      send();
      rdchk(32'h3F4, 32'h2000);
   endtask
   task automatic t_map();
      logic [31:0] bad [4] = '{32'h0, 32'h3AC, 32'h3B2, 32'h400};
      foreach (bad[i]) rdchk(bad[i], 32'h0, 1'b1);
      wr(32'h3D8, 32'hFFFF);
      rdchk(32'h3D8, 32'h0);
   endtask
   task automatic t_words();
      u.loopStat = 16'h5AA5;
      u.linkStat0 = 64'h1111_2222_3333_4444;
      u.linkStat1 = 64'h5555_6666_7777_8888;
      u.unitRunErr = 64'h0A0B_0C0D_0E0F_02FF;
      u.lowBatt = 1'b1;
      u.ioVerErr = 1'b1;
      u.stepFlag = 1'b1;
      u.specUnitErr = 1'b1;
      s.cmplVld0 = 1'b1;
      s.cmplCode0 = 8'h07;
      s.cmplVld1 = 1'b1;
      s.cmplCode1 = 8'h09;
      s.falVld = 1'b1;
      s.falCode = 8'h3C;
      s.resVld = 1'b1;
      s.resFlags = 5'h16;
      send();
      wr(32'h3B0, 32'h0);
      rdchk(32'h3B0, 32'h5AA5);
      rdchk(32'h3B4, 32'h0907);
      rdchk(32'h3B8, 32'h4444);
      rdchk(32'h3C4, 32'h1111);
      rdchk(32'h3D4, 32'h5555);
      rdchk(32'h3DC, 32'h02FF);
      rdchk(32'h3F4, 32'h253C);
      // Repeated reads catch the pulse bits in several phases
      repeat (4) rdchk(32'h3F8, 32'h8080, 1'b0, 32'hFFFC);
      repeat (6) rdchk(32'h3FC, 32'h00B0, 1'b0, 32'hFFF8);
   endtask
   task automatic t_remote();
      s.rioVld = 1'b1;
      s.rioIsMaster = 1'b1;
      s.rioMasterNo = 1'b1;
      s.rioRack = 3'h5;
      send();
      s.rioVld = 1'b1;
      s.rioOptUnit = 5'h13;
      s.rioUpper = 1'b1;
      send();
      s.rioVld = 1'b1;
      s.rioOptUnit = 5'h1F;
      send();
      rdchk(32'h3EC, 32'hB158);
      chk({31'h0, ctrlOut.alarmFlash}, 32'h1);
      rdchk(32'h3F4, 32'h1000, 1'b0, 32'h1000);
      pop();
      rdchk(32'h3EC, 32'h1318);
      wr(32'h3EC, 32'h0);
      rdchk(32'h3EC, 32'h1318);
      pop();
      rdchk(32'h3EC, 32'h1F08);
      pop();
      rdchk(32'h3EC, 32'h0);
   endtask
   task automatic t_link();
      s.netErr0 = 1'b1;
      s.netErr1 = 1'b1;
      s.hostErr = 3'h7;
      u.linkAct1 = 1'b1;
      send();
      rdchk(32'h3F0, 32'h0169);
      rdchk(32'h3F4, 32'h0800, 1'b0, 32'h0800);
      wr(32'h3F0, 32'h0012);
      rdchk(32'h3F0, 32'h0032);
      chk({30'h0, ctrlOut.netEnable}, 32'h3);
      wr(32'h3F0, 32'h0212);
      wr(32'h3F0, 32'h0212);
      wr(32'h3F0, 32'h0012);
      rdchk(32'h3F0, 32'h0032);
      chk(32'(rstCnt[1]), 32'h1);
      u.hostMultilevel = 1'b1;
      send();
      wr(32'h3F0, 32'h2092);
      wr(32'h3F0, 32'h0012);
      u.hostMultilevel = 1'b0;
      send();
      chk(32'(rstCnt[0]), 32'h0);
      chk(32'(rstCnt[2]), 32'h0);
      wr(32'h3F0, 32'h2092);
      wr(32'h3F0, 32'h0012);
      rdchk(32'h3F0, 32'h0032);
      chk(32'(rstCnt[0]), 32'h1);
      chk(32'(rstCnt[2]), 32'h1);
      wr(32'h3F0, 32'h9812);
      rdchk(32'h3F0, 32'h9832);
      chk({29'h0, ctrlOut.forceHold, ctrlOut.dataRetain,
           ctrlOut.outputsOff}, 32'h7);
      wr(32'h3F4, 32'h0);
      rdchk(32'h3F4, 32'h0, 1'b0, 32'h1800);
      chk({31'h0, ctrlOut.alarmFlash}, 32'h0);
   endtask
   initial begin
      #100000;
      failures++;
      report_and_stop();
   end
   initial begin
      rst_b = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 32'h0;
      pwdata = 32'h0;
      u = '0;
      s = '0;
      failures = 0;
      checks = 0;
      rstCnt = '{0, 0, 0};
      repeat (3) @(posedge sys_clk);
      rst_b <= 1'b1;
      t_reset();
      t_map();
      t_words();
      t_remote();
      t_link();
      report_and_stop();
   end
endmodule

// ### tb/ssw_unit_model.sv
// Behavioural link and remote units driving the bank's unit inputs
`timescale 1ns/1ps
module ssw_unit_model
   import ssw_pkg::*;
(
   input  wire logic       sys_clk,
   output ssw_unit_in_type unitIn
);
   initial unitIn = '0;
   // Strobes ride on the levels one cycle only: one report a cycle
   task automatic apply(input ssw_unit_in_type lv, st);
      @(posedge sys_clk);
      unitIn <= lv | st;
      @(posedge sys_clk);
      unitIn <= lv;
   endtask
endmodule
